// [rtl/cocr_regs.sv]
`timescale 1ns/10ps
// Operation
// - Configuration bit 12 enables the duty stabilizer and resets to one.
// - Configuration bit 11 sets a 0 or 90 degree double rate phase.
// - Configuration bit 10 selects single rate when one, double when zero.
// - Configuration bit 9 picks standard swing at one, reduced at zero.
// - Configuration bit 8 picks the single rate edge, rising when one.
// - Offset bits 15:8 hold the magnitude and bit 7 the sign.
// - A 32-bit header, address, data frame shifts in while select is low in extended control mode.
// - The write-only registers act only in extended control mode.
module cocr_regs
  import cocr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serial_clock_i,
  input wire logic serial_in_i,
  input wire logic serial_select_n_i,
  input wire logic extended_mode_i,
  input wire logic swing_select_pin_i,
  input wire logic edge_select_pin_i,
  output logic duty_stabilizer_en_o,
  output logic out_clock_phase_sel_o,
  output logic single_rate_sel_o,
  output logic output_swing_sel_o,
  output logic edge_select_o,
  output logic [7:0] offset_magnitude_o,
  output logic offset_negative_o
);
  import cocr_pkg::*;

  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [1:0] data_sync;
    logic [1:0] sel_sync;
    logic [1:0] ext_sync;
    logic [1:0] swing_sync;
    logic [1:0] edge_sync;
    logic [31:0] shift;
    logic [5:0] count;
    logic [15:0] config_reg;
    logic [15:0] offset_reg;
    logic duty;
    logic phase;
    logic rate;
    logic swing;
    logic edge_sel;
    logic [7:0] mag;
    logic sign;
  } cocr_state_type;

  cocr_state_type state_reg;
  cocr_state_type state_next;
  logic sclk_rise;
  logic [31:0] frame;

  assign sclk_rise = state_reg.sclk_sync[1] & ~state_reg.sclk_sync[2];
  assign frame = {state_reg.shift[30:0], state_reg.data_sync[1]};

  always_comb
  begin
    state_next = state_reg;
    state_next.sclk_sync = {state_reg.sclk_sync[1:0], serial_clock_i};
    state_next.data_sync = {state_reg.data_sync[0], serial_in_i};
    state_next.sel_sync = {state_reg.sel_sync[0], serial_select_n_i};
    state_next.ext_sync = {state_reg.ext_sync[0], extended_mode_i};
    state_next.swing_sync = {state_reg.swing_sync[0], swing_select_pin_i};
    state_next.edge_sync = {state_reg.edge_sync[0], edge_select_pin_i};
    if (state_reg.sel_sync[1] || !state_reg.ext_sync[1])
    begin
      state_next.count = 6'h00;
    end
    else if (sclk_rise)
    begin
      state_next.shift = frame;
      if (state_reg.count == 6'(FRAME_BITS - 1))
      begin
        state_next.count = 6'h00;
        if (frame[31:20] == HEADER_PATTERN)
        begin
          if (frame[19:16] == ADDR_CONFIG)
          begin
            state_next.config_reg = frame[15:0];
          end
          if (frame[19:16] == ADDR_OFFSET_I)
          begin
            state_next.offset_reg = frame[15:0];
          end
        end
      end
      else
      begin
        state_next.count = state_reg.count + 6'h01;
      end
    end
    if (state_reg.ext_sync[1])
    begin
      state_next.duty = state_reg.config_reg[DUTY_BIT];
      state_next.phase = state_reg.config_reg[PHASE_BIT];
      state_next.rate = state_reg.config_reg[RATE_BIT];
      state_next.swing = state_reg.config_reg[SWING_BIT];
      state_next.edge_sel = state_reg.config_reg[EDGE_BIT];
      state_next.mag = state_reg.offset_reg[MAG_MSB:MAG_LSB];
      state_next.sign = state_reg.offset_reg[SIGN_BIT];
    end
    else
    begin
      state_next.duty = DUTY_NORMAL;
      state_next.phase = PHASE_NORMAL;
      state_next.rate = RATE_NORMAL;
      state_next.swing = state_reg.swing_sync[1];
      state_next.edge_sel = state_reg.edge_sync[1];
      state_next.mag = MAG_NORMAL;
      state_next.sign = SIGN_NORMAL;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
      state_reg.sel_sync <= 2'h3;
      state_reg.config_reg <= CONFIG_RESET;
      state_reg.offset_reg <= OFFSET_RESET;
      state_reg.duty <= DUTY_NORMAL;
      state_reg.swing <= CONFIG_RESET[SWING_BIT];
      state_reg.edge_sel <= EDGE_NORMAL_DEFAULT;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign duty_stabilizer_en_o = state_reg.duty;
  assign out_clock_phase_sel_o = state_reg.phase;
  assign single_rate_sel_o = state_reg.rate;
  assign output_swing_sel_o = state_reg.swing;
  assign edge_select_o = state_reg.edge_sel;
  assign offset_magnitude_o = state_reg.mag;
  assign offset_negative_o = state_reg.sign;

  sequence last_bit_s;
    !state_reg.sel_sync[1] && state_reg.ext_sync[1] && sclk_rise
      && state_reg.count == 6'h1F;
  endsequence

  sequence good_cfg_s;
    frame[31:20] == HEADER_PATTERN && frame[19:16] == ADDR_CONFIG;
  endsequence

  sequence good_off_s;
    frame[31:20] == HEADER_PATTERN && frame[19:16] == ADDR_OFFSET_I;
  endsequence

  cfg_write_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    last_bit_s and good_cfg_s
    |=> state_reg.config_reg == $past(frame[15:0]))
    else $error("Configuration write lost.");
  off_write_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    last_bit_s and good_off_s
    |=> state_reg.offset_reg == $past(frame[15:0]))
    else $error("Offset write lost.");
  bad_header_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    last_bit_s and frame[31:20] != HEADER_PATTERN
    |=> $stable(state_reg.config_reg) && $stable(state_reg.offset_reg))
    else $error("Write taken with bad header.");
  bad_addr_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    last_bit_s and frame[19:16] != ADDR_CONFIG
      && frame[19:16] != ADDR_OFFSET_I
    |=> $stable(state_reg.config_reg) && $stable(state_reg.offset_reg))
    else $error("Write taken at an unused address.");
  idle_hold_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state_reg.sel_sync[1] || !state_reg.ext_sync[1]
    |=> $stable(state_reg.config_reg) && $stable(state_reg.offset_reg))
    else $error("Register changed while the port was idle.");
  count_range_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state_reg.count <= 6'(FRAME_BITS - 1))
    else $error("Bit counter ran past the frame.");
  duty_out_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state_reg.ext_sync[1]
    |=> duty_stabilizer_en_o == $past(state_reg.config_reg[DUTY_BIT]))
    else $error("Duty stabilizer output wrong.");
  phase_out_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state_reg.ext_sync[1]
    |=> out_clock_phase_sel_o == $past(state_reg.config_reg[PHASE_BIT]))
    else $error("Clock phase output wrong.");
  rate_out_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state_reg.ext_sync[1]
    |=> single_rate_sel_o == $past(state_reg.config_reg[RATE_BIT]))
    else $error("Rate output wrong.");
  swing_out_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state_reg.ext_sync[1]
    |=> output_swing_sel_o == $past(state_reg.config_reg[SWING_BIT]))
    else $error("Swing output wrong.");
  edge_out_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state_reg.ext_sync[1]
    |=> edge_select_o == $past(state_reg.config_reg[EDGE_BIT]))
    else $error("Edge output wrong.");
  offset_out_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state_reg.ext_sync[1]
    |=> offset_magnitude_o == $past(state_reg.offset_reg[MAG_MSB:MAG_LSB])
      && offset_negative_o == $past(state_reg.offset_reg[SIGN_BIT]))
    else $error("Offset output wrong.");
  normal_mode_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !state_reg.ext_sync[1]
    |=> duty_stabilizer_en_o && !out_clock_phase_sel_o && !single_rate_sel_o
      && offset_magnitude_o == MAG_NORMAL && !offset_negative_o)
    else $error("Registers acted in normal mode.");
  normal_pins_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !state_reg.ext_sync[1]
    |=> output_swing_sel_o == $past(state_reg.swing_sync[1])
      && edge_select_o == $past(state_reg.edge_sync[1]))
    else $error("Pin settings not followed in normal mode.");
  rate_mode_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state_reg.ext_sync[1] && state_reg.config_reg[RATE_BIT]
    |=> single_rate_sel_o)
    else $error("Single rate not selected.");
  edge_mode_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state_reg.ext_sync[1] && !state_reg.config_reg[EDGE_BIT]
    |=> !edge_select_o)
    else $error("Falling edge not selected.");
endmodule : cocr_regs

// [rtl/cocr_pkg.sv]
package cocr_pkg;
  localparam logic [11:0] HEADER_PATTERN = 12'h001;
  localparam int FRAME_BITS = 32;
  localparam logic [3:0] ADDR_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_OFFSET_I = 4'h2;
  localparam logic [15:0] CONFIG_RESET = 16'hB2FF;
  localparam logic [15:0] OFFSET_RESET = 16'h007F;
  localparam int DUTY_BIT = 12;
  localparam int PHASE_BIT = 11;
  localparam int RATE_BIT = 10;
  localparam int SWING_BIT = 9;
  localparam int EDGE_BIT = 8;
  localparam int MAG_MSB = 15;
  localparam int MAG_LSB = 8;
  localparam int SIGN_BIT = 7;
  localparam logic DUTY_NORMAL = 1'b1;
  localparam logic PHASE_NORMAL = 1'b0;
  localparam logic RATE_NORMAL = 1'b0;
  localparam logic EDGE_NORMAL_DEFAULT = 1'b0;
  localparam logic [7:0] MAG_NORMAL = 8'h00;
  localparam logic SIGN_NORMAL = 1'b0;
endpackage : cocr_pkg

// [tb/cocr_host.sv]
`timescale 1ns/10ps
module cocr_host (
  input wire logic clk_i,
  output logic sclk_o,
  output logic serial_in_o,
  output logic sel_n_o
);
  initial
  begin
    sclk_o = 1'b0;
    serial_in_o = 1'b0;
    sel_n_o = 1'b1;
  end
  // Sends one whole frame, MSB first, clock held high four cycles and low eight.
  task automatic send(input logic [11:0] head, input logic [3:0] addr,
    input logic [15:0] data);
    logic [31:0] frame;
    frame = {head, addr, data};
    @(posedge clk_i) sel_n_o <= 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      serial_in_o <= frame[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    serial_in_o <= ~frame[0];
    sel_n_o <= 1'b1;
  endtask : send
  // Interleave sampling is never on here, so config writes are safe.
  task automatic write_config(input logic [4:0] f);
    send(12'h001, 4'h1, {3'h5, f, 8'hFF});
  endtask : write_config
  task automatic write_offset(input logic [7:0] mag, input logic neg);
    send(12'h001, 4'h2, {mag, neg, 7'h7F});
  endtask : write_offset
endmodule : cocr_host

// [tb/test_cocr_regs.sv]
`timescale 1ns/10ps
module test_cocr_regs;
  import cocr_pkg::*;
  logic clk_i, rst_i, sclk, serial_in, sel_n, ext, swing_pin, edge_pin;
  logic duty, phase, single, swing, edge_sel, neg;
  logic [7:0] mag;
  int error_cnt = 0;
  int compares = 0;
  logic [4:0] cfg [3] = '{5'h0D, 5'h1F, 5'h00};
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  cocr_host i_host (.clk_i(clk_i), .sclk_o(sclk), .serial_in_o(serial_in),
    .sel_n_o(sel_n));
  cocr_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .serial_clock_i(sclk),
    .serial_in_i(serial_in), .serial_select_n_i(sel_n),
    .extended_mode_i(ext), .swing_select_pin_i(swing_pin),
    .edge_select_pin_i(edge_pin), .duty_stabilizer_en_o(duty),
    .out_clock_phase_sel_o(phase), .single_rate_sel_o(single),
    .output_swing_sel_o(swing), .edge_select_o(edge_sel),
    .offset_magnitude_o(mag), .offset_negative_o(neg));
  task automatic chk(input logic [13:0] exp);
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    compares++;
    if ({duty, phase, single, swing, edge_sel, mag, neg} !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time,
        {duty, phase, single, swing, edge_sel, mag, neg}, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    rst_i = 1'b1;
    ext = 1'b1;
    swing_pin = 1'b0;
    edge_pin = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({5'h12, 8'h00, 1'h0});
    foreach (cfg[k])
    begin
      i_host.write_config(cfg[k]);
      chk({cfg[k], 8'h00, 1'h0});
    end
    i_host.write_offset(8'hA5, 1'b1);
    chk({5'h00, 8'hA5, 1'h1});
    i_host.send(12'h003, 4'h1, 16'hBFFF);
    chk({5'h00, 8'hA5, 1'h1});
    i_host.send(12'h001, 4'h0, 16'hBFFF);
    chk({5'h00, 8'hA5, 1'h1});
    i_host.write_config(5'h1A);
    ext <= 1'b0;
    chk({5'h11, 8'h00, 1'h0});
    @(posedge clk_i);
    swing_pin <= 1'b1;
    edge_pin <= 1'b0;
    chk({5'h12, 8'h00, 1'h0});
    i_host.write_offset(8'h3C, 1'b0);
    ext <= 1'b1;
    chk({5'h1A, 8'hA5, 1'h1});
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({5'h12, 8'h00, 1'h0});
    i_host.write_offset(8'h3C, 1'b0);
    chk({5'h12, 8'h3C, 1'h0});
    tally_and_finish();
  end
endmodule : test_cocr_regs
